// file: sim/gpio_pin_function_select_checker.sv
// port assertions for the pin function select
`timescale 1ns/10ps
`default_nettype none
module pinmux_checker
	import pinmux_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic arst_n, // reset, low active
	input wire logic data_wr, // data write strobe
	input wire logic [2:0] data_port, // port selected
	input wire logic [7:0] data_addr_mask, // address mask lines
	input wire logic [7:0] data_wdata, // write data
	input wire logic [7:0] data_rdata, // read data
	input wire logic [7:0] adc_trig_en, // trigger enables
	input wire logic [7:0] port_irq, // port interrupts
	input wire logic adc_trigger, // converter start
	input wire logic [63:0] pad_out, // pad levels
	input wire logic [63:0] pad_oe, // pad enables
	input wire logic [63:0] pad_pu, // pull-ups
	input wire logic [63:0] pad_pd, // pull-downs
	input wire logic [127:0] pad_drive, // drive codes
	input wire logic [63:0] pad_ie, // input enables
	input wire logic [63:0] pad_analog, // analog selects
	input wire logic [63:0] periph_in, // levels to peripherals
	input wire logic [255:0] pin_code // function codes
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	int n_high;
	always_comb begin
		n_high = 0;
		for (int i = 0; i < 64; i++) n_high += int'(pad_drive[2*i +: 2] == DRV_18MA);
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	reset_defaults_a: assert property ($rose(arst_n) |-> pad_pd == 64'h0 &&
		pin_code == 256'h3333_0000_1100_0011_1111 && pad_pu == 64'h000f_0000 && pad_ie == 64'h000f_0c3f)
		else $error("reset pin state wrong");
	code_gate_a: assert property (pin_code[131:128] != 4'h0 |-> pad_ie[32])
		else $error("function code without digital enable");
	den_off_a: assert property (!pad_ie[33] |-> !periph_in[33] && !pad_oe[33])
		else $error("disabled pin reads or drives");
	analog_iso_a: assert property (pad_analog[33] |-> !pad_ie[33])
		else $error("analog select with digital enable");
	masked_write_a: assert property (data_wr && data_port == 3'h3 && !data_addr_mask[0]
		|=> $stable(pad_out[24])) else $error("masked bit written");
	write_lands_a: assert property (data_wr && data_port == 3'h3 && data_addr_mask[0] &&
		pad_oe[24] |=> pad_out[24] == $past(data_wdata[0])) else $error("output write lost");
	read_mask_a: assert property (1'b1 |=> (data_rdata & ~$past(data_addr_mask)) == 8'h00)
		else $error("unmasked read bit");
	trigger_after_a: assert property ($rose(|(port_irq & adc_trig_en)) |-> ##[0:2] adc_trigger)
		else $error("converter start missing");
	drive_limit_a: assert property (n_high <= MAX_HIGH_DRIVE)
		else $error("too many high drive pads");
	cover property (adc_trigger);
	cover property (pad_analog[33]);
	cover property (n_high == MAX_HIGH_DRIVE);
endmodule // pinmux_checker
bind gpio_pin_function_select pinmux_checker u_pinmux_checker (.clk(clk), .arst_n(arst_n),
	.data_wr(data_wr), .data_port(data_port), .data_addr_mask(data_addr_mask),
	.data_wdata(data_wdata), .data_rdata(data_rdata), .adc_trig_en(adc_trig_en),
	.port_irq(port_irq), .adc_trigger(adc_trigger), .pad_out(pad_out), .pad_oe(pad_oe),
	.pad_pu(pad_pu), .pad_pd(pad_pd), .pad_drive(pad_drive), .pad_ie(pad_ie),
	.pad_analog(pad_analog), .periph_in(periph_in), .pin_code(pin_code));
`default_nettype wire

// file: sim/gpio_pin_function_select_tb.sv
// self-checking bench for the pin function select
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_function_select_tb;
	import pinmux_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, data_wr = 1'b0, cfg_wr = 1'b0, dir_wr = 1'b0;
	logic drive_wr = 1'b0, sense_wr = 1'b0, irq_mask_wr = 1'b0, adc_trigger, drive_refused;
	logic [2:0] data_port = 3'h0, cfg_port = 3'h0, cfg_sel = 3'h0;
	logic [7:0] data_addr_mask = 8'h0, data_wdata = 8'h0, cfg_pin_mask = 8'h0, cfg_wdata = 8'h0;
	logic [7:0] dir_wdata = 8'h0, irq_clear = 8'h0, adc_trig_en = 8'h40;
	logic [7:0] data_rdata, irq_raw, port_irq;
	logic [3:0] cfg_code = 4'h0;
	logic [63:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_slew, pad_ie, pad_analog, periph_in;
	logic [63:0] periph_out = 64'h0, periph_oe = 64'h0, ext_level = 64'h0, ext_drv = 64'h0;
	logic [127:0] pad_drive;
	logic [255:0] pin_code;
	int n_mismatch = 0, samples_checked = 0, cycles = 0;
	gpio_pin_function_select u_gpio_pin_function_select (.clk(clk), .arst_n(arst_n),
		.data_wr(data_wr), .data_port(data_port), .data_addr_mask(data_addr_mask),
		.data_wdata(data_wdata), .data_rdata(data_rdata), .cfg_wr(cfg_wr), .cfg_port(cfg_port),
		.cfg_sel(cfg_sel), .cfg_pin_mask(cfg_pin_mask), .cfg_wdata(cfg_wdata), .cfg_code(cfg_code),
		.dir_wr(dir_wr), .dir_wdata(dir_wdata), .drive_wr(drive_wr), .sense_wr(sense_wr),
		.irq_mask_wr(irq_mask_wr), .irq_clear(irq_clear), .adc_trig_en(adc_trig_en),
		.irq_raw(irq_raw), .port_irq(port_irq), .adc_trigger(adc_trigger),
		.drive_refused(drive_refused), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pu(pad_pu), .pad_pd(pad_pd), .pad_slew(pad_slew), .pad_drive(pad_drive),
		.pad_ie(pad_ie), .pad_analog(pad_analog), .periph_out(periph_out),
		.periph_oe(periph_oe), .periph_in(periph_in), .pin_code(pin_code));
	pad_board u_pad_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
		.pad_pd(pad_pd), .ext_level(ext_level), .ext_drv(ext_drv), .pad_in(pad_in));
	always #2 clk = ~clk;
	task automatic stop_test();
		$display("compares %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a hung scenario counts against the run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic cmp(input logic [255:0] exp, input logic [255:0] act);
		samples_checked++;
		if (act !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t exp=%0h got=%0h", $time, exp, act);
		end
	endtask
	// kind: 0 field, 1 direction, 2 drive, 3 sense, 4 interrupt mask
	task automatic cfg(input int kind, input logic [2:0] port, input logic [2:0] sel,
			input logic [7:0] pins, input logic [7:0] val, input logic [3:0] code);
		@(negedge clk);
		{cfg_port, cfg_sel, cfg_pin_mask, cfg_wdata, cfg_code} = {port, sel, pins, val, code};
		dir_wdata = val;
		{irq_mask_wr, sense_wr, drive_wr, dir_wr, cfg_wr} = 5'(1 << kind);
		@(negedge clk);
		{irq_mask_wr, sense_wr, drive_wr, dir_wr, cfg_wr} = 5'h0;
	endtask
	task automatic dwr(input logic [7:0] mask, input logic [7:0] val);
		@(negedge clk);
		{data_wr, data_port, data_addr_mask, data_wdata} = {1'b1, 3'h3, mask, val};
		@(negedge clk);
		data_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] mask, input logic [7:0] exp);
		@(negedge clk);
		{data_port, data_addr_mask} = {3'h3, mask};
		@(negedge clk);
		cmp(exp, data_rdata);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		cmp(96'h00003333_00001100_00111111, pin_code);
		cmp({64'h000f_0000, 64'h000f_0c3f, 64'h0}, {pad_pu, pad_ie, pad_oe});
		cmp(256'h0, {pad_pd, pad_analog, pad_drive});
	endtask
	task automatic t_toggle();
		cfg(0, 3'h3, CFG_DEN, 8'h03, 8'h03, 4'h0);
		cfg(1, 3'h3, 3'h0, 8'h01, 8'h01, 4'h0);
		ext_drv[25] = 1'b1;
		ext_level[25] = 1'b1;
		for (int i = 0; i < 4; i++) begin
			dwr(8'h01, {7'h0, ~i[0]});
			cmp({1'b1, ~i[0]}, {pad_oe[24], pad_out[24]});
		end
		dwr(8'h00, 8'h01);
		cmp(1'b0, pad_out[24]);
		rd(8'h02, 8'h02);
		rd(8'hfd, 8'h00);
	endtask
	task automatic t_alt();
		periph_out[32] = 1'b1;
		periph_oe[32] = 1'b1;
		cfg(0, 3'h4, CFG_ALT, 8'h01, 8'h01, 4'h0);
		cfg(0, 3'h4, CFG_CODE, 8'h01, 8'h00, 4'h2);
		cmp({4'h0, 1'b0}, {pin_code[131:128], pad_oe[32]});
		cfg(0, 3'h4, CFG_DEN, 8'h01, 8'h01, 4'h0);
		cmp({8'h02, 2'b11}, {pin_code[135:128], pad_oe[32], pad_out[32]});
		repeat (3) @(negedge clk);
		cmp(1'b1, periph_in[32]);
	endtask
	task automatic t_analog();
		ext_drv[34:33] = 2'b11;
		ext_level[34:33] = 2'b11;
		cfg(0, 3'h4, CFG_AMS, 8'h02, 8'h02, 4'h0);
		repeat (4) @(negedge clk);
		cmp(4'b0100, {pad_analog[34:33], periph_in[34:33]});
		cfg(0, 3'h4, CFG_DEN, 8'h02, 8'h02, 4'h0);
		cmp(1'b0, pad_analog[33]);
	endtask
	task automatic t_drive();
		cfg(2, 3'h5, 3'h0, 8'h0f, 8'h00, {2'h0, DRV_18MA});
		cfg(2, 3'h5, 3'h0, 8'h10, 8'h00, {2'h0, DRV_18MA});
		cmp({1'b1, 16'h00ff}, {drive_refused, pad_drive[95:80]});
		cfg(2, 3'h5, 3'h0, 8'h10, 8'h00, {2'h0, DRV_8MA});
		cfg(0, 3'h5, CFG_SLEW, 8'h10, 8'h10, 4'h0);
		cfg(0, 3'h5, CFG_PD, 8'h20, 8'h20, 4'h0);
		cmp({1'b0, 16'h02ff, 2'b11}, {drive_refused, pad_drive[95:80], pad_slew[44], pad_pd[45]});
		cfg(2, 3'h5, 3'h0, 8'h30, 8'h00, {2'h0, DRV_18MA});
		cmp({1'b1, 16'h02ff}, {drive_refused, pad_drive[95:80]});
	endtask
	task automatic t_irq();
		sense_t m [5] = '{SENSE_RISE, SENSE_FALL, SENSE_BOTH, SENSE_HIGH, SENSE_LOW};
		logic [4:0] st = 5'b10010;
		logic seen = 1'b0;
		cfg(0, 3'h6, CFG_DEN, 8'h01, 8'h01, 4'h0);
		ext_drv[48] = 1'b1;
		for (int i = 0; i < 5; i++) begin
			ext_level[48] = st[i];
			repeat (5) @(negedge clk);
			cfg(3, 3'h6, 3'h0, 8'h01, 8'h00, {1'b0, m[i]});
			irq_clear = 8'h01;
			@(negedge clk);
			irq_clear = 8'h00;
			@(negedge clk);
			cmp(1'b0, irq_raw[0]);
			ext_level[48] = ~st[i];
			repeat (5) @(negedge clk);
			cmp(1'b1, irq_raw[0]);
		end
		cmp(1'b0, port_irq[6]);
		cfg(4, 3'h6, 3'h0, 8'h01, 8'h01, 4'h0);
		cmp(1'b1, port_irq[6]);
		repeat (3) begin
			@(negedge clk);
			seen = seen | adc_trigger;
		end
		cmp(1'b1, seen);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		t_defaults();
		t_toggle();
		t_alt();
		t_analog();
		t_drive();
		t_irq();
		arst_n = 1'b0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		t_defaults();
		stop_test();
	end
endmodule // gpio_pin_function_select_tb
`default_nettype wire

// file: sim/pad_board.sv
// board side of the pads: pulls, external drivers and floating pins
`timescale 1ns/10ps
`default_nettype none
module pad_board (
	input wire logic clk, // system clock
	input wire logic [63:0] pad_out, // chip level
	input wire logic [63:0] pad_oe, // chip drives
	input wire logic [63:0] pad_pu, // weak pull-up
	input wire logic [63:0] pad_pd, // weak pull-down
	input wire logic [63:0] ext_level, // board level
	input wire logic [63:0] ext_drv, // board drives
	output logic [63:0] pad_in // resolved pin level
);
	logic [63:0] float_r = 64'h0;
	// undriven pins wander so a stale level is never mistaken for a real one
	always_ff @(posedge clk) float_r <= ~float_r;
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			if (pad_oe[i]) pad_in[i] = pad_out[i];
			else if (ext_drv[i]) pad_in[i] = ext_level[i];
			else if (pad_pu[i]) pad_in[i] = 1'b1;
			else if (pad_pd[i]) pad_in[i] = 1'b0;
			else pad_in[i] = float_r[i];
		end
	end
endmodule // pad_board
`default_nettype wire

// file: src/gpio_pin_function_select.sv
// eight port pin function select, pad control, interrupts and converter trigger
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_function_select
	import pinmux_pkg::*;
(
	input wire logic clk, // system clock, 250 MHz
	input wire logic arst_n, // power-on or external reset, low active
	// data access
	input wire logic data_wr, // data write strobe
	input wire logic [pinmux_pkg::PORT_W-1:0] data_port, // port selected
	input wire logic [pinmux_pkg::ADDR_W-1:0] data_addr_mask, // address mask lines
	input wire logic [7:0] data_wdata, // write data
	output logic [7:0] data_rdata, // masked read data
	// configuration access
	input wire logic cfg_wr, // configuration write strobe
	input wire logic [pinmux_pkg::PORT_W-1:0] cfg_port, // port selected
	input wire logic [2:0] cfg_sel, // field selected
	input wire logic [7:0] cfg_pin_mask, // pins written
	input wire logic [7:0] cfg_wdata, // bit values for one bit fields
	input wire logic [3:0] cfg_code, // function code, drive or sense value
	input wire logic dir_wr, // direction write strobe
	input wire logic [7:0] dir_wdata, // output direction per pin
	input wire logic drive_wr, // drive strength write strobe
	input wire logic sense_wr, // interrupt sense write strobe
	input wire logic irq_mask_wr, // interrupt mask write strobe
	input wire logic [7:0] irq_clear, // clear pulses for cfg_port
	input wire logic [7:0] adc_trig_en, // port may trigger converter
	output logic [7:0] irq_raw, // raw status of cfg_port
	output logic [7:0] port_irq, // interrupt per port
	output logic adc_trigger, // converter sample start pulse
	output logic drive_refused, // last drive write was a refused 18 mA request
	// pads
	input wire logic [63:0] pad_in, // pad input levels
	output logic [63:0] pad_out, // pad output level
	output logic [63:0] pad_oe, // pad drive enable, high drives
	output logic [63:0] pad_pu, // weak pull-up
	output logic [63:0] pad_pd, // weak pull-down
	output logic [63:0] pad_slew, // slew control
	output logic [127:0] pad_drive, // two drive bits per pad
	output logic [63:0] pad_ie, // digital input enable
	output logic [63:0] pad_analog, // isolated converter input select
	// peripherals
	input wire logic [63:0] periph_out, // peripheral output level per pin
	input wire logic [63:0] periph_oe, // peripheral drive request per pin
	output logic [63:0] periph_in, // pin level to peripherals
	output logic [255:0] pin_code // active function code per pin
);
	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	logic [7:0] alt_function_select_reg [8];
	logic [7:0] digital_enable_reg [8];
	logic [7:0] analog_mode_reg [8];
	logic [7:0] pull_up_reg [8];
	logic [7:0] pull_down_reg [8];
	logic [7:0] open_drain_r [8];
	logic [7:0] slew_r [8];
	logic [7:0] dir_r [8];
	logic [7:0] data_r [8];
	logic [7:0] irq_mask_r [8];
	logic [3:0] port_function_code_reg [64];
	logic [1:0] drive_r [64];
	logic [2:0] sense_r [64];
	logic drive_refused_r;
	logic [63:0] sync_in;
	logic [7:0] raw [8];
	logic [7:0] irq_w;
	logic [7:0] irq_prev_r;

	function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] m,
			input logic [7:0] v);
		upd = (cur & ~m) | (v & m);
	endfunction

	function automatic logic [7:0] rst_val(input int p, input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] c);
		rst_val = (p == PORT_A) ? a : (p == PORT_B) ? b : (p == PORT_C) ? c : 8'h00;
	endfunction

	// true when the configuration access addresses port p
	function automatic logic port_hit(input int p);
		port_hit = (cfg_port == PORT_W'(p));
	endfunction

	// true when the configuration access covers pin i
	function automatic logic pin_hit(input int i);
		pin_hit = port_hit(i / PINS) && cfg_pin_mask[i % PINS];
	endfunction

	// reset function code: serial exceptions take code 1, debug pins code 3
	function automatic logic [3:0] rst_code(input int i);
		logic [7:0] ser;
		ser = rst_val(i / PINS, RST_SERIAL_A, RST_SERIAL_B, 8'h00);
		if (i / PINS == PORT_C && RST_DEBUG_C[i % PINS])
			rst_code = CODE_DEBUG;
		else if (ser[i % PINS])
			rst_code = CODE_SERIAL;
		else
			rst_code = CODE_NONE;
	endfunction

	// ----------------------------------------
	// high drive limit
	// ----------------------------------------
	// a write that would push the count past the limit is refused whole,
	// so a request covering several pins can never overshoot it
	logic [6:0] high_cnt;
	logic [6:0] new_cnt;
	always_comb begin
		high_cnt = 7'h00;
		new_cnt = 7'h00;
		for (int i = 0; i < N_PINS; i++) begin
			high_cnt = high_cnt + 7'(drive_r[i] == DRV_18MA);
			new_cnt = new_cnt + 7'(pin_hit(i) && drive_r[i] != DRV_18MA);
		end
	end
	wire cfg_sel_hi = (cfg_code[1:0] == DRV_18MA);
	wire drive_over = cfg_sel_hi && (high_cnt + new_cnt > 7'(MAX_HIGH_DRIVE));

	// ----------------------------------------
	// per port registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int p = 0; p < N_PORTS; p++) begin
				alt_function_select_reg[p] <= rst_val(p, RST_SERIAL_A, RST_SERIAL_B, RST_DEBUG_C);
				digital_enable_reg[p] <= rst_val(p, RST_SERIAL_A, RST_SERIAL_B, RST_DEBUG_C);
				pull_up_reg[p] <= rst_val(p, 8'h00, 8'h00, RST_DEBUG_C);
				analog_mode_reg[p] <= 8'h00;
				pull_down_reg[p] <= 8'h00;
				open_drain_r[p] <= 8'h00;
				slew_r[p] <= 8'h00;
				dir_r[p] <= 8'h00;
				data_r[p] <= 8'h00;
				irq_mask_r[p] <= 8'h00;
			end
		end else begin
			for (int p = 0; p < N_PORTS; p++) begin
				if (cfg_wr && cfg_port == PORT_W'(p)) begin
					unique case (cfg_field_t'(cfg_sel))
						CFG_ALT: alt_function_select_reg[p] <=
							upd(alt_function_select_reg[p], cfg_pin_mask, cfg_wdata);
						CFG_DEN: digital_enable_reg[p] <=
							upd(digital_enable_reg[p], cfg_pin_mask, cfg_wdata);
						CFG_AMS: analog_mode_reg[p] <= upd(analog_mode_reg[p], cfg_pin_mask, cfg_wdata);
						CFG_PU: pull_up_reg[p] <= upd(pull_up_reg[p], cfg_pin_mask, cfg_wdata);
						CFG_PD: pull_down_reg[p] <= upd(pull_down_reg[p], cfg_pin_mask, cfg_wdata);
						CFG_OD: open_drain_r[p] <= upd(open_drain_r[p], cfg_pin_mask, cfg_wdata);
						CFG_SLEW: slew_r[p] <= upd(slew_r[p], cfg_pin_mask, cfg_wdata);
						CFG_CODE: ;
					endcase
				end
				if (dir_wr && cfg_port == PORT_W'(p))
					dir_r[p] <= upd(dir_r[p], cfg_pin_mask, dir_wdata);
				if (irq_mask_wr && cfg_port == PORT_W'(p))
					irq_mask_r[p] <= upd(irq_mask_r[p], cfg_pin_mask, cfg_wdata);
				// a write lands in one cycle, so a toggle every two cycles is easy
				if (data_wr && data_port == PORT_W'(p))
					data_r[p] <= upd(data_r[p], data_addr_mask, data_wdata);
			end
		end
	end

	// ----------------------------------------
	// per pin fields
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < N_PINS; i++) begin
				port_function_code_reg[i] <= rst_code(i);
				drive_r[i] <= DRV_2MA;
				sense_r[i] <= 3'(SENSE_RISE);
			end
			drive_refused_r <= 1'b0;
		end else begin
			for (int i = 0; i < N_PINS; i++) begin
				if (pin_hit(i)) begin
					if (cfg_wr && cfg_field_t'(cfg_sel) == CFG_CODE)
						port_function_code_reg[i] <= cfg_code;
					if (sense_wr)
						sense_r[i] <= cfg_code[2:0];
				end
			end
			// a refused request leaves every addressed pad as it was
			if (drive_wr) begin
				drive_refused_r <= drive_over;
				for (int i = 0; i < N_PINS; i++) begin
					if (pin_hit(i) && !drive_over)
						drive_r[i] <= cfg_code[1:0];
				end
			end
		end
	end

	// ----------------------------------------
	// pad inputs and interrupts
	// ----------------------------------------
	for (genvar p = 0; p < N_PORTS; p++) begin : g_port
		logic [2:0] sense_p [8];
		for (genvar b = 0; b < PINS; b++) begin : g_bit
			assign sense_p[b] = sense_r[p * PINS + b];
		end
		pin_sync u_sync (
			.clk(clk),
			.arst_n(arst_n),
			.d(pad_in[p * PINS +: PINS]),
			.q(sync_in[p * PINS +: PINS])
		);
		port_irq u_irq (
			.clk(clk),
			.arst_n(arst_n),
			.level(sync_in[p * PINS +: PINS] & digital_enable_reg[p]),
			.mask(irq_mask_r[p]),
			.sense(sense_p),
			.clear(port_hit(p) ? irq_clear : 8'h00),
			.raw_r(raw[p]),
			.irq(irq_w[p])
		);
	end

	// ----------------------------------------
	// pad and peripheral routing
	// ----------------------------------------
	for (genvar i = 0; i < N_PINS; i++) begin : g_pin
		localparam int P = i / PINS;
		localparam int B = i % PINS;
		wire digital_enable_bit = digital_enable_reg[P][B];
		wire alt = alt_function_select_reg[P][B];
		wire periph = alt & digital_enable_bit;
		wire drv_lvl = periph ? periph_out[i] : data_r[P][B];
		wire drv_req = digital_enable_bit & (periph ? periph_oe[i] : dir_r[P][B]);
		wire od = open_drain_r[P][B];
		// open drain only ever pulls low; a high level leaves the pad to its pull
		assign pad_out[i] = od ? 1'b0 : drv_lvl;
		assign pad_oe[i] = drv_req & (~od | ~drv_lvl);
		assign pad_pu[i] = pull_up_reg[P][B];
		assign pad_pd[i] = pull_down_reg[P][B];
		assign pad_slew[i] = slew_r[P][B] & (drive_r[i] == DRV_8MA);
		assign pad_drive[2 * i +: 2] = drive_r[i];
		assign pad_ie[i] = digital_enable_bit;
		// isolation only when software has asked for it and digital is off
		assign pad_analog[i] = analog_mode_reg[P][B] & ~digital_enable_bit;
		assign periph_in[i] = periph & sync_in[i];
		assign pin_code[4 * i +: 4] = periph ? port_function_code_reg[i] : CODE_NONE;
	end

	// ----------------------------------------
	// read data, masked and registered
	// ----------------------------------------
	wire [7:0] sel_in = sync_in[data_port * PINS +: PINS] & digital_enable_reg[data_port];
	wire [7:0] sel_rd = (sel_in & ~dir_r[data_port]) | (data_r[data_port] & dir_r[data_port]);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			data_rdata <= 8'h00;
		else
			data_rdata <= sel_rd & data_addr_mask;
	end

	// ----------------------------------------
	// status and converter trigger
	// ----------------------------------------
	// only a rising port interrupt starts a sequence, so a level interrupt
	// that stays asserted does not retrigger the converter every cycle
	wire [7:0] irq_rise = irq_w & ~irq_prev_r & adc_trig_en;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_prev_r <= 8'h00;
			adc_trigger <= 1'b0;
		end else begin
			irq_prev_r <= irq_w;
			adc_trigger <= |irq_rise;
		end
	end
	assign irq_raw = raw[cfg_port];
	assign port_irq = irq_w;
	assign drive_refused = drive_refused_r;
endmodule // gpio_pin_function_select
`default_nettype wire

// file: src/pin_sync.sv
// two-flop synchroniser for one port of pad inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
	input wire logic clk, // system clock
	input wire logic arst_n, // async reset, low active
	input wire logic [7:0] d, // raw pad levels
	output logic [7:0] q // synchronised levels
);
	logic [7:0] meta_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= 8'h00;
			q <= 8'h00;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // pin_sync
`default_nettype wire

// file: src/pinmux_pkg.sv
// constants and types shared by the pin function select design
package pinmux_pkg;
	localparam int N_PORTS = 8;
	localparam int PINS = 8;
	localparam int N_PINS = N_PORTS * PINS;
	localparam int CODE_W = 4;
	localparam int ADDR_W = 8;
	localparam int PORT_W = 3;
	localparam int PAD_W = 3;
	localparam int DRIVE_W = 2;
	// pad configuration bundle: pull-up, pull-down, open drain
	localparam int PAD_PU = 0;
	localparam int PAD_PD = 1;
	localparam int PAD_OD = 2;
	// drive codes
	localparam logic [1:0] DRV_2MA = 2'h0;
	localparam logic [1:0] DRV_4MA = 2'h1;
	localparam logic [1:0] DRV_8MA = 2'h2;
	localparam logic [1:0] DRV_18MA = 2'h3;
	localparam int MAX_HIGH_DRIVE = 4;
	// port indices
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	// function codes restored by reset
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_SERIAL = 4'h1;
	localparam logic [3:0] CODE_DEBUG = 4'h3;
	// per-port reset masks of the exception pins
	localparam logic [7:0] RST_SERIAL_A = 8'h3f;
	localparam logic [7:0] RST_SERIAL_B = 8'h0c;
	localparam logic [7:0] RST_DEBUG_C = 8'h0f;
	// configuration fields selectable by cfg_sel
	typedef enum logic [2:0] {
		CFG_ALT = 3'h0,
		CFG_DEN = 3'h1,
		CFG_AMS = 3'h2,
		CFG_PU = 3'h3,
		CFG_PD = 3'h4,
		CFG_OD = 3'h5,
		CFG_SLEW = 3'h6,
		CFG_CODE = 3'h7
	} cfg_field_t;
	// interrupt sense modes
	typedef enum logic [2:0] {
		SENSE_RISE = 3'h0,
		SENSE_FALL = 3'h1,
		SENSE_BOTH = 3'h3,
		SENSE_HIGH = 3'h2,
		SENSE_LOW = 3'h6
	} sense_t;
endpackage

// file: src/port_irq.sv
// interrupt sensing for one eight pin port
`timescale 1ns/10ps
`default_nettype none
module port_irq
	import pinmux_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic arst_n, // async reset, low active
	input wire logic [7:0] level, // synchronised pin levels
	input wire logic [7:0] mask, // per pin interrupt enable
	input wire logic [2:0] sense [8], // per pin sense mode
	input wire logic [7:0] clear, // per pin clear pulse
	output logic [7:0] raw_r, // sticky raw status
	output logic irq // masked any
);
	logic [7:0] prev_r;
	logic [7:0] hit;
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			unique case (sense_t'(sense[i]))
				SENSE_RISE: hit[i] = level[i] & ~prev_r[i];
				SENSE_FALL: hit[i] = ~level[i] & prev_r[i];
				SENSE_BOTH: hit[i] = level[i] ^ prev_r[i];
				SENSE_HIGH: hit[i] = level[i];
				SENSE_LOW: hit[i] = ~level[i];
				default: hit[i] = 1'b0;
			endcase
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= 8'h00;
			raw_r <= 8'h00;
		end else begin
			prev_r <= level;
			// set wins over clear
			raw_r <= (raw_r & ~clear) | hit;
		end
	end
	assign irq = |(raw_r & mask);
endmodule // port_irq
`default_nettype wire
